// ===== src/rts_sequencer.v
// Summary of operation
// - Start code 00 goes to the low-power point, choice 1 enters Idle, select 1 makes Idle Sleep.
// - Sleep keeps only the RC clock alive so the sequencer timers keep counting.
// - With idle exit 1 the first timer expiry moves Idle to Receive; both timers set the period.
// - In preamble-wake listen the second timer bounds receive time without a preamble.
// - Receive exit 110 turns the sequencer off on preamble found, leaving the radio in Receive.
// - In sync-wake listen a preamble search timeout with code 10 returns to low power.
// - A found preamble keeps Receive until a sync match or the second timer ends, then polls on.
// - Receive exit 101 turns the sequencer off on sync match, leaving the radio in Receive.
// - Repeat transmit with the sequencer gives periodic beacons with no host help.
// - Idle exit 0 goes to Transmit on first timer, transmit exit 0 back on packet done.
// - The beacon loop runs until the host sets the halt bit.
`include "rts_map.vh"
`default_nettype none
module rts_sequencer (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        preamble_found,
   input  wire        sync_word_match,
   input  wire        packet_done_tx,
   input  wire        checksum_good,
   input  wire        queue_threshold,
   input  wire        queue_drained,
   output reg  [2:0]  radio_mode,
   output reg         rc_osc_only,
   output reg         tx_repeat_payload,
   output reg         sequencer_running,
   output reg  [4:0]  mappable_output_pin
);
   localparam ST_OFF   = 3'd0;
   localparam ST_LOWPW = 3'd1;
   localparam ST_IDLE  = 3'd2;
   localparam ST_RX    = 3'd3;
   localparam ST_TX    = 3'd4;
   localparam ST_STBY  = 3'd5;

   reg [`RTS_CFG_WIDTH-1:0] sequencer_config_one;
   reg [15:0]               first_sleep_period;
   reg [15:0]               second_window_period;
   reg [15:0]               preamble_search_timeout;
   reg [9:0]                pin_select;
   reg [2:0]                state;
   reg [2:0]                next_state;
   reg [15:0]               tick_cycle;
   reg                      tick;
   reg [15:0]               t1_cnt;
   reg [15:0]               t2_cnt;
   reg [15:0]               to_cnt;
   reg                      t2_run;
   reg                      to_run;
   reg                      pre_seen;
   reg                      next_t2_run;
   reg                      next_to_run;
   reg                      next_pre_seen;
   reg                      start_req;
   reg                      halt_req;
   reg [2:0]                next_mode;
   reg [31:0]               next_rdata;
   reg                      next_err;

   wire       idle_sel   = sequencer_config_one[`RTS_CFG_IDLE_SEL];
   wire [1:0] start_tr   = sequencer_config_one[`RTS_CFG_START_LO+1:`RTS_CFG_START_LO];
   wire       lowpw      = sequencer_config_one[`RTS_CFG_LOWPWR];
   wire       idle_exit  = sequencer_config_one[`RTS_CFG_IDLE_EXIT];
   wire [2:0] rx_exit    = sequencer_config_one[`RTS_CFG_RXEXIT_LO+2:`RTS_CFG_RXEXIT_LO];
   wire [1:0] rxto_tr    = sequencer_config_one[`RTS_CFG_RXTO_LO+1:`RTS_CFG_RXTO_LO];
   wire       tx_exit    = sequencer_config_one[`RTS_CFG_TXEXIT];
   wire       repeat_en  = sequencer_config_one[`RTS_CFG_REPEAT];
   wire       pre_route  = sequencer_config_one[`RTS_CFG_PRE_ROUTE];
   // First timer only runs out once the second timer of the cycle is over
   wire       t1_done    = (state == ST_IDLE) && !t2_run && tick && (t1_cnt <= 16'h0001);
   wire       t2_done    = t2_run && tick && (t2_cnt <= 16'h0001);
   wire       to_done    = to_run && tick && (to_cnt <= 16'h0001);
   wire       wr_en      = psel && penable && pwrite;
   wire       sync_mode  = (rx_exit == `RTS_RXEXIT_SYNC);

   // Pin source select for one mappable output
   function pin_src;
      input [1:0] code;
      input [2:0] idx;
      begin
         case (code)
            2'h0:    pin_src = (idx == 3'd3) ? queue_drained : queue_threshold;
            2'h1:    pin_src = checksum_good;
            2'h2:    pin_src = packet_done_tx;
            default: pin_src = (idx == 3'd4) ? (preamble_found & pre_route) : sync_word_match;
         endcase
      end
   endfunction

   // Divider giving one 64 us tick, running on the always-on clock
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cycle <= 16'h0000;
         tick       <= 1'b0;
      end else if (tick_cycle == `RTS_TICK_CYCLES - 1) begin
         tick_cycle <= 16'h0000;
         tick       <= 1'b1;
      end else begin
         tick_cycle <= tick_cycle + 16'h0001;
         tick       <= 1'b0;
      end
   end

   // Sequencer next state
   always @* begin
      next_state    = state;
      next_t2_run   = t2_run;
      next_to_run   = to_run;
      next_pre_seen = pre_seen | preamble_found;
      if (t2_done)
         next_t2_run = 1'b0;
      if (to_done || preamble_found)
         next_to_run = 1'b0;
      case (state)
         ST_OFF: begin
            next_pre_seen = 1'b0;
            next_t2_run   = 1'b0;
            next_to_run   = 1'b0;
            if (start_req) begin
               if (start_tr == `RTS_START_LOWPWR)
                  next_state = ST_LOWPW;
               else
                  next_state = ST_STBY;
            end
         end
         ST_LOWPW: begin
            next_pre_seen = 1'b0;
            next_state    = lowpw ? ST_IDLE : ST_STBY;
         end
         ST_IDLE: begin
            next_pre_seen = 1'b0;
            if (t1_done) begin
               next_t2_run = 1'b1;
               next_to_run = sync_mode;
               next_state  = idle_exit ? ST_RX : ST_TX;
            end
         end
         ST_RX: begin
            if (rx_exit == `RTS_RXEXIT_PRE && preamble_found)
               next_state = ST_OFF;
            else if (sync_mode && sync_word_match && pre_seen)
               next_state = ST_OFF;
            else if (sync_mode && to_done && !pre_seen && !preamble_found &&
                     rxto_tr == `RTS_RXTO_LOWPWR)
               next_state = ST_LOWPW;
            else if (t2_done && !(sync_mode && pre_seen))
               next_state = ST_LOWPW;
            else if (t2_done)
               next_state = ST_LOWPW;
         end
         ST_TX: begin
            if (packet_done_tx && !tx_exit)
               next_state = ST_LOWPW;
            else if (packet_done_tx)
               next_state = ST_OFF;
         end
         ST_STBY:  next_state = ST_STBY;
         default:  next_state = ST_OFF;
      endcase
      if (halt_req)
         next_state = ST_OFF;
   end

   // Radio mode follows state; off keeps last mode
   always @* begin
      case (next_state)
         ST_IDLE:  next_mode = idle_sel ? `RTS_MODE_SLEEP : `RTS_MODE_STANDBY;
         ST_RX:    next_mode = `RTS_MODE_RX;
         ST_TX:    next_mode = `RTS_MODE_TX;
         ST_STBY:  next_mode = `RTS_MODE_STANDBY;
         ST_LOWPW: next_mode = radio_mode;
         default:  next_mode = radio_mode;
      endcase
   end

   // State, timers and radio outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state             <= ST_OFF;
         t1_cnt            <= 16'h0000;
         t2_cnt            <= 16'h0000;
         to_cnt            <= 16'h0000;
         t2_run            <= 1'b0;
         to_run            <= 1'b0;
         pre_seen          <= 1'b0;
         radio_mode        <= `RTS_MODE_SLEEP;
         rc_osc_only       <= 1'b0;
         tx_repeat_payload <= 1'b0;
         sequencer_running <= 1'b0;
         mappable_output_pin <= 5'h00;
      end else begin
         state    <= next_state;
         t2_run   <= next_t2_run;
         to_run   <= next_to_run;
         pre_seen <= next_pre_seen;
         if (next_state == ST_IDLE && (state != ST_IDLE || t2_done))
            t1_cnt <= first_sleep_period;
         else if (tick && t1_cnt != 16'h0000)
            t1_cnt <= t1_cnt - 16'h0001;
         if (t1_done)
            t2_cnt <= second_window_period;
         else if (tick && t2_cnt != 16'h0000)
            t2_cnt <= t2_cnt - 16'h0001;
         if (t1_done)
            to_cnt <= preamble_search_timeout;
         else if (tick && to_cnt != 16'h0000)
            to_cnt <= to_cnt - 16'h0001;
         radio_mode        <= next_mode;
         rc_osc_only       <= (next_state == ST_IDLE) && idle_sel;
         tx_repeat_payload <= repeat_en && (next_state == ST_TX);
         sequencer_running <= (next_state != ST_OFF);
         mappable_output_pin <= {pin_src(pin_select[9:8], 3'd4), pin_src(pin_select[7:6], 3'd3),
                                 pin_src(pin_select[5:4], 3'd2), pin_src(pin_select[3:2], 3'd1),
                                 pin_src(pin_select[1:0], 3'd0)};
      end
   end

   // APB register writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sequencer_config_one    <= `RTS_CFG_RESET;
         first_sleep_period      <= `RTS_TIMER_RESET;
         second_window_period    <= `RTS_TIMER_RESET;
         preamble_search_timeout <= `RTS_RXTO_RESET;
         pin_select              <= 10'h000;
         start_req               <= 1'b0;
         halt_req                <= 1'b0;
      end else begin
         start_req <= 1'b0;
         halt_req  <= 1'b0;
         if (wr_en) begin
            case (paddr)
               `RTS_ADDR_CTRL: begin
                  start_req <= pwdata[`RTS_CTRL_START];
                  halt_req  <= pwdata[`RTS_CTRL_HALT];
               end
               `RTS_ADDR_CFG:    sequencer_config_one    <= pwdata[`RTS_CFG_WIDTH-1:0];
               `RTS_ADDR_FIRST_SLEEP_PERIOD: first_sleep_period      <= pwdata[15:0];
               `RTS_ADDR_SECOND_WINDOW_PERIOD: second_window_period    <= pwdata[15:0];
               `RTS_ADDR_RXTO:   preamble_search_timeout <= pwdata[15:0];
               `RTS_ADDR_PINMAP: pin_select              <= pwdata[9:0];
               default:          pin_select              <= pin_select;
            endcase
         end
      end
   end

   // APB read mux and error decode
   always @* begin
      next_err = 1'b0;
      case (paddr)
         `RTS_ADDR_CTRL:   next_rdata = 32'h00000000;
         `RTS_ADDR_CFG:    next_rdata = {19'h00000, sequencer_config_one};
         `RTS_ADDR_FIRST_SLEEP_PERIOD: next_rdata = {16'h0000, first_sleep_period};
         `RTS_ADDR_SECOND_WINDOW_PERIOD: next_rdata = {16'h0000, second_window_period};
         `RTS_ADDR_RXTO:   next_rdata = {16'h0000, preamble_search_timeout};
         `RTS_ADDR_STATUS: next_rdata = {25'h0000000, pre_seen, sequencer_running, state, radio_mode[1:0]};
         `RTS_ADDR_PINMAP: next_rdata = {22'h000000, pin_select};
         default: begin
            next_rdata = 32'h00000000;
            next_err   = 1'b1;
         end
      endcase
   end

   // Zero wait state APB answer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && next_err;
         prdata  <= (psel && !penable && !pwrite) ? next_rdata : 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// ===== inc/rts_map.vh
`ifndef RTS_MAP_VH
`define RTS_MAP_VH
// APB byte offsets
`define RTS_ADDR_CTRL      12'h000
`define RTS_ADDR_CFG       12'h004
`define RTS_ADDR_FIRST_SLEEP_PERIOD    12'h008
`define RTS_ADDR_SECOND_WINDOW_PERIOD    12'h00C
`define RTS_ADDR_RXTO      12'h010
`define RTS_ADDR_STATUS    12'h014
`define RTS_ADDR_PINMAP    12'h018
// Control bits (write one, self clearing)
`define RTS_CTRL_START     0
`define RTS_CTRL_HALT      1
// Configuration field positions
`define RTS_CFG_IDLE_SEL   0
`define RTS_CFG_START_LO   1
`define RTS_CFG_LOWPWR     3
`define RTS_CFG_IDLE_EXIT  4
`define RTS_CFG_RXEXIT_LO  5
`define RTS_CFG_RXTO_LO    8
`define RTS_CFG_TXEXIT     10
`define RTS_CFG_REPEAT     11
`define RTS_CFG_PRE_ROUTE  12
`define RTS_CFG_WIDTH      13
`define RTS_CFG_RESET      13'h0000
// Transition codes
`define RTS_START_LOWPWR   2'h0
`define RTS_RXEXIT_PRE     3'h6
`define RTS_RXEXIT_SYNC    3'h5
`define RTS_RXTO_LOWPWR    2'h2
// Timers: 64 us units, 50 MHz pclk
`define RTS_TICK_NS        64000
`define RTS_CLK_NS         20
`define RTS_TICK_CYCLES    (`RTS_TICK_NS / `RTS_CLK_NS)
`define RTS_TIMER_RESET    16'h0001
`define RTS_RXTO_RESET     16'h0001
// Radio operating modes
`define RTS_MODE_SLEEP     3'h0
`define RTS_MODE_STANDBY   3'h1
`define RTS_MODE_TX        3'h3
`define RTS_MODE_RX        3'h5
`endif

// ===== dv/rts_seq_monitor.sv
`include "rts_map.vh"
`default_nettype none
module rts_seq_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [2:0]  radio_mode,
   input wire logic        rc_osc_only,
   input wire logic        tx_repeat_payload,
   input wire logic        sequencer_running
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Setup cycle of a bus transfer
   sequence s_setup;
      psel && !penable;
   endsequence
   // Completed write to the control word
   sequence s_ctrl_wr;
      pready && psel && penable && pwrite && paddr == `RTS_ADDR_CTRL;
   endsequence
   // Three quiet cycles with the sequencer off
   sequence s_quiet_off;
      (!sequencer_running && !psel) [*3];
   endsequence
   a_apb_no_wait: assert property (s_setup |=> pready) else $error("pready late");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
   a_bad_addr_err: assert property (pready && paddr > 12'h018 |-> pslverr)
      else $error("no error on unmapped address");
   a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_sleep_rc_only: assert property (rc_osc_only |-> radio_mode == `RTS_MODE_SLEEP)
      else $error("rc only outside sleep");
   a_repeat_in_tx: assert property (tx_repeat_payload |-> radio_mode == `RTS_MODE_TX)
      else $error("repeat flag outside transmit");
   a_off_mode_held: assert property (s_quiet_off |-> $stable(radio_mode))
      else $error("mode moved while off");
   a_halt_stops: assert property (s_ctrl_wr ##0 pwdata[1] |-> ##[1:3] !sequencer_running)
      else $error("halt ignored");
   a_start_runs: assert property (s_ctrl_wr ##0 pwdata[1:0] == 2'h1 |-> ##[1:3] sequencer_running)
      else $error("start ignored");
endmodule
bind rts_sequencer rts_seq_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .radio_mode(radio_mode), .rc_osc_only(rc_osc_only),
   .tx_repeat_payload(tx_repeat_payload), .sequencer_running(sequencer_running));
`default_nettype wire

// ===== dv/rts_radio_model.sv
`include "rts_map.vh"
`default_nettype none
module rts_radio_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [2:0] radio_mode,
   input  wire logic       pre_en,
   input  wire logic       sync_en,
   output var  logic       preamble_found,
   output var  logic       sync_word_match,
   output var  logic       packet_done_tx
);
   logic [7:0] dwell;
   logic       on_air;
   assign on_air = radio_mode == `RTS_MODE_RX || radio_mode == `RTS_MODE_TX;
   // Dwell in receive or transmit, events at fixed points of it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dwell <= 8'h00;
      end else begin
         dwell <= !on_air ? 8'h00 : (dwell == 8'hFF ? dwell : dwell + 8'h01);
      end
   end
   assign preamble_found = pre_en && radio_mode == `RTS_MODE_RX && dwell == 8'h28;
   assign sync_word_match = sync_en && radio_mode == `RTS_MODE_RX && dwell == 8'h64;
   assign packet_done_tx = radio_mode == `RTS_MODE_TX && dwell == 8'h3C;
endmodule
`default_nettype wire

// ===== dv/radio_top_sequencer_listen_beacon_tb_top.sv
`include "rts_map.vh"
`default_nettype none
module radio_top_sequencer_listen_beacon_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        pre_en = 0, sync_en = 0, checksum_good = 0, queue_threshold = 0;
   logic        queue_drained = 0, pready, pslverr, rc_osc_only, tx_repeat_payload;
   logic        sequencer_running, preamble_found, sync_word_match, packet_done_tx, e;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q, r;
   logic [2:0]  radio_mode;
   logic [4:0]  mappable_output_pin;
   int          n_mismatch = 0, checks_done = 0;
   always #10 pclk = ~pclk;
   rts_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .preamble_found(preamble_found), .sync_word_match(sync_word_match),
      .packet_done_tx(packet_done_tx), .checksum_good(checksum_good),
      .queue_threshold(queue_threshold), .queue_drained(queue_drained),
      .radio_mode(radio_mode), .rc_osc_only(rc_osc_only),
      .tx_repeat_payload(tx_repeat_payload), .sequencer_running(sequencer_running),
      .mappable_output_pin(mappable_output_pin));
   rts_radio_model radio_u (.pclk(pclk), .presetn(presetn), .radio_mode(radio_mode),
      .pre_en(pre_en), .sync_en(sync_en), .preamble_found(preamble_found),
      .sync_word_match(sync_word_match), .packet_done_tx(packet_done_tx));
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      checks_done++;
      if (g !== x) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, x, g);
      end
   endtask
   // One bus transfer, then one idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 50) chk("pready", 1, 0);
      @(posedge pclk);
   endtask
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
      apb(0, a, 0);
      chk(nm, x, q);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic wait_mode(input logic [2:0] m, input int lim);
      int n;
      n = 0;
      while (radio_mode !== m && n < lim) begin
         @(posedge pclk);
         n++;
      end
      chk("radio mode", m, radio_mode);
   endtask
   // Configuration word from the transition choices
   function automatic logic [31:0] cfg(input logic ie, input logic [2:0] rx,
                                       input logic [1:0] to, input logic rp);
      cfg = 32'h0;
      cfg[`RTS_CFG_IDLE_SEL] = 1'b1;
      cfg[`RTS_CFG_LOWPWR] = 1'b1;
      cfg[`RTS_CFG_IDLE_EXIT] = ie;
      cfg[`RTS_CFG_RXEXIT_LO +: 3] = rx;
      cfg[`RTS_CFG_RXTO_LO +: 2] = to;
      cfg[`RTS_CFG_REPEAT] = rp;
      cfg[`RTS_CFG_PRE_ROUTE] = 1'b1;
   endfunction
   task automatic end_sim();
      $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Watchdog over the whole run
   initial begin
      #1600000;
      chk("watchdog", 0, 1);
      end_sim();
   end
   initial begin
      void'($urandom(32'h29F8));
      repeat (12) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      rd("cfg", `RTS_ADDR_CFG, `RTS_CFG_RESET);
      rd("first_sleep_period", `RTS_ADDR_FIRST_SLEEP_PERIOD, `RTS_TIMER_RESET);
      rd("rxto", `RTS_ADDR_RXTO, `RTS_RXTO_RESET);
      rd("unmapped", 12'h01C, 0);
      chk("unmapped err", 1, e);
      r = $urandom & 32'hFFFF;
      apb(1, `RTS_ADDR_SECOND_WINDOW_PERIOD, r);
      rd("second_window_period", `RTS_ADDR_SECOND_WINDOW_PERIOD, r);
      $display("test registers done");
      apb(1, `RTS_ADDR_FIRST_SLEEP_PERIOD, 1);
      apb(1, `RTS_ADDR_SECOND_WINDOW_PERIOD, 1);
      apb(1, `RTS_ADDR_PINMAP, 1);
      apb(1, `RTS_ADDR_CFG, cfg(1, `RTS_RXEXIT_PRE, 0, 0));
      rd("cfg back", `RTS_ADDR_CFG, cfg(1, `RTS_RXEXIT_PRE, 0, 0));
      apb(1, `RTS_ADDR_CTRL, 1);
      checksum_good <= 1;
      queue_threshold <= $urandom;
      queue_drained <= $urandom;
      idle(4);
      chk("pin0", 1, mappable_output_pin[0]);
      chk("pin1", queue_threshold, mappable_output_pin[1]);
      chk("pin2", queue_threshold, mappable_output_pin[2]);
      chk("pin3", queue_drained, mappable_output_pin[3]);
      chk("rc only", 1, rc_osc_only);
      chk("idle sleep", `RTS_MODE_SLEEP, radio_mode);
      wait_mode(`RTS_MODE_RX, 4000);
      wait_mode(`RTS_MODE_SLEEP, 4000);
      pre_en <= 1;
      wait_mode(`RTS_MODE_RX, 7000);
      idle(80);
      chk("pre off", 0, sequencer_running);
      chk("pre rx", `RTS_MODE_RX, radio_mode);
      idle(300);
      chk("held rx", `RTS_MODE_RX, radio_mode);
      $display("test preamble wake done");
      pre_en <= 0;
      apb(1, `RTS_ADDR_CTRL, 2);
      apb(1, `RTS_ADDR_SECOND_WINDOW_PERIOD, 2);
      apb(1, `RTS_ADDR_RXTO, 1);
      apb(1, `RTS_ADDR_CFG, cfg(1, `RTS_RXEXIT_SYNC, `RTS_RXTO_LOWPWR, 0));
      apb(1, `RTS_ADDR_CTRL, 1);
      wait_mode(`RTS_MODE_RX, 4000);
      wait_mode(`RTS_MODE_SLEEP, 4000);
      pre_en <= 1;
      wait_mode(`RTS_MODE_RX, 10000);
      idle(3400);
      chk("sync wait rx", `RTS_MODE_RX, radio_mode);
      wait_mode(`RTS_MODE_SLEEP, 7000);
      sync_en <= 1;
      wait_mode(`RTS_MODE_RX, 10000);
      idle(150);
      chk("sync off", 0, sequencer_running);
      chk("sync rx", `RTS_MODE_RX, radio_mode);
      $display("test sync wake done");
      pre_en <= 0;
      sync_en <= 0;
      apb(1, `RTS_ADDR_CTRL, 2);
      apb(1, `RTS_ADDR_SECOND_WINDOW_PERIOD, 1);
      apb(1, `RTS_ADDR_CFG, cfg(0, 0, 0, 1));
      apb(1, `RTS_ADDR_CTRL, 1);
      wait_mode(`RTS_MODE_TX, 7000);
      chk("repeat tx", 1, tx_repeat_payload);
      wait_mode(`RTS_MODE_SLEEP, 200);
      wait_mode(`RTS_MODE_TX, 7000);
      chk("beacon loops", 1, sequencer_running);
      apb(1, `RTS_ADDR_CTRL, 2);
      idle(3);
      chk("beacon halted", 0, sequencer_running);
      $display("test beacon done");
      end_sim();
   end
endmodule
`default_nettype wire
